// >>> pkg/sgram_fe_pkg.sv
// Shared constants and types for the graphics DRAM pin front end.
// Assumes one command clock link domain and one system clock core domain.
package sgram_fe_pkg;
   localparam int BANK_W = 4;
   localparam int NUM_BANKS = 16;
   localparam int ADDR_W = 16;
   localparam int DQ_W = 32;
   localparam int BYTES = 4;
   localparam int BYTE_W = 8;
   localparam int PAIR_W = 16;
   localparam int NUM_PAIRS = 2;
   localparam int SYNC_STAGES = 2;
   // Address bits 12..8 and 14 arrive on the true phase, the rest on the complement.
   localparam logic [ADDR_W-1:0] ADDR_TRUE_MASK = 16'h5F00;
   localparam int PRE_ALL_BIT = 8;
   // Strobe codes {row, column, write}, active low; replace from the command table.
   localparam logic [2:0] STB_ACT = 3'h3;
   localparam logic [2:0] STB_RD = 3'h5;
   localparam logic [2:0] STB_WR = 3'h4;
   localparam logic [2:0] STB_PRE = 3'h2;
   localparam logic [2:0] STB_REF = 3'h1;
   localparam logic [2:0] STB_MRS = 3'h0;
   localparam int READ_LAT = 9;
   localparam int WRITE_LAT = 5;
   localparam int BURST_CK = 2;
   localparam int LAT_W = 6;
   typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS} cmd_e;
   typedef enum logic [1:0] {PWR_ACTIVE, PWR_PRE_PD, PWR_ACT_PD, PWR_SELF_REF} pwr_e;
endpackage

// >>> pkg/cap_if.sv
// Carrier between the command capture logic and the core.
// Assumes the link side drives everything and the core only samples it.
`timescale 1ns/100ps
interface cap_if;
   import sgram_fe_pkg::*;
   cmd_e cmd;
   logic [BANK_W-1:0] bank;
   logic [ADDR_W-1:0] addr;
   logic cmd_tgl;
   logic cke_b;
   logic rd_win;
   logic wr_win;
   modport link (output cmd, bank, addr, cmd_tgl, cke_b, rd_win, wr_win);
   modport core (input cmd, bank, addr, cmd_tgl, cke_b, rd_win, wr_win);
endinterface

// >>> core/cmd_capture.sv
// Command clock side: samples strobes, bank and both address halves, counts latency.
// Assumes pins are timed to the command clock; the core synchronises toggle, enable and windows, and samples the command word directly.
`timescale 1ns/100ps
module cmd_capture
   import sgram_fe_pkg::*;
#(
   parameter int RD_LAT = READ_LAT,
   parameter int WR_LAT = WRITE_LAT
) (
   input wire logic cmd_clk_true_i,
   input wire logic cmd_clk_comp_i,
   input wire logic rst_b_i,
   input wire logic [2:0] strobe_b_i,
   input wire logic cke_b_i,
   input wire logic [BANK_W-1:0] bank_i,
   input wire logic [ADDR_W-1:0] addr_i,
   cap_if.link cap
);
   typedef struct packed {
      cmd_e pend_cmd;
      logic [BANK_W-1:0] pend_bank;
      logic [ADDR_W-1:0] pend_addr;
      cmd_e cmd;
      logic [BANK_W-1:0] bank;
      logic [ADDR_W-1:0] addr;
      logic tgl;
      logic cke_b;
      logic [LAT_W-1:0] rd_cnt;
      logic [LAT_W-1:0] wr_cnt;
   } link_s;
   link_s cur_ff;
   link_s nxt_cur;
   logic [SYNC_STAGES-1:0] rst_sync_ff;
   logic [ADDR_W-1:0] comp_addr_ff;
   cmd_e dec_cmd;

   // Reset asserts at once and releases on the command clock.
   always_ff @(posedge cmd_clk_true_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_sync_ff <= '0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end

   // Complement phase half of the address.
   always_ff @(posedge cmd_clk_comp_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         comp_addr_ff <= '0;
      end else begin
         comp_addr_ff <= addr_i & ~ADDR_TRUE_MASK;
      end
   end

   always_comb begin
      unique case (strobe_b_i)
         STB_ACT: dec_cmd = CMD_ACT;
         STB_RD: dec_cmd = CMD_RD;
         STB_WR: dec_cmd = CMD_WR;
         STB_PRE: dec_cmd = CMD_PRE;
         STB_REF: dec_cmd = CMD_REF;
         STB_MRS: dec_cmd = CMD_MRS;
         default: dec_cmd = CMD_NOP;
      endcase
   end

   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.cke_b = cke_b_i;
      // Inputs are dead while the clock enable is high, except a refresh that enters self refresh.
      nxt_cur.pend_cmd = (!cke_b_i || dec_cmd == CMD_REF) ? dec_cmd : CMD_NOP;
      nxt_cur.pend_bank = bank_i;
      nxt_cur.pend_addr = addr_i & ADDR_TRUE_MASK;
      if (cur_ff.pend_cmd != CMD_NOP) begin
         nxt_cur.cmd = cur_ff.pend_cmd;
         nxt_cur.bank = cur_ff.pend_bank;
         nxt_cur.addr = cur_ff.pend_addr | comp_addr_ff;
         nxt_cur.tgl = ~cur_ff.tgl;
      end
      // Latency counts whole command clock cycles.
      if (cur_ff.rd_cnt != '0) begin
         nxt_cur.rd_cnt = cur_ff.rd_cnt - LAT_W'(1);
      end
      if (cur_ff.wr_cnt != '0) begin
         nxt_cur.wr_cnt = cur_ff.wr_cnt - LAT_W'(1);
      end
      if (cur_ff.pend_cmd == CMD_RD) begin
         nxt_cur.rd_cnt = LAT_W'(RD_LAT + BURST_CK - 1);
      end
      if (cur_ff.pend_cmd == CMD_WR) begin
         nxt_cur.wr_cnt = LAT_W'(WR_LAT + BURST_CK - 1);
      end
   end

   always_ff @(posedge cmd_clk_true_i or negedge rst_sync_ff[SYNC_STAGES-1]) begin
      if (!rst_sync_ff[SYNC_STAGES-1]) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign cap.cmd = cur_ff.cmd;
   assign cap.bank = cur_ff.bank;
   assign cap.addr = cur_ff.addr;
   assign cap.cmd_tgl = cur_ff.tgl;
   assign cap.cke_b = cur_ff.cke_b;
   assign cap.rd_win = (cur_ff.rd_cnt != '0) && (cur_ff.rd_cnt <= LAT_W'(BURST_CK));
   assign cap.wr_win = (cur_ff.wr_cnt != '0) && (cur_ff.wr_cnt <= LAT_W'(BURST_CK));
endmodule

// >>> core/sgram_front_end.sv
// Pin front end of a graphics DRAM: command, bank state, power state and data lanes.
// Assumes a host controller on the pins and user logic on CLK_I for array data.
// Functional notes
// - Bank inputs pick target bank of commands.
// - Bank inputs pick mode register on set.
// - Bank inputs sampled on true clock rise.
// - Commands captured once per true clock rise.
// - Address captured on true and complement rises.
// - Latencies counted in true clock cycles.
// - Data clocks capture writes and launch reads.
// - Low pair lanes 15..0, high pair 31..16.
// - Clock enable high disables drivers and all inputs except refresh.
// - Enable rise picks precharge, active or self refresh.
// - Three strobes decode the command.
// - Reset low acts at once, no clock.
// - Termination off while reset is low.
// - Reset accepted at any time.
// - One shared 32-lane bidirectional data bus.
// - Each inversion flag covers one byte lane.
// - Precharge bit 8 high closes all banks.
// - Address bits split between true and complement phases.
// - Each check output covers one byte lane.
`timescale 1ns/100ps
module sgram_front_end
   import sgram_fe_pkg::*;
#(
   parameter int RD_LAT = READ_LAT,
   parameter int WR_LAT = WRITE_LAT
) (
   input wire logic CLK_I,
   input wire logic RST_B_I,
   input wire logic CMD_CLOCK_TRUE_I,
   input wire logic CMD_CLOCK_COMP_I,
   input wire logic DATA_CLOCK_LOW_PAIR_TRUE_I,
   input wire logic DATA_CLOCK_HIGH_PAIR_TRUE_I,
   input wire logic RAS_B_I,
   input wire logic CAS_B_I,
   input wire logic WE_B_I,
   input wire logic CKE_B_I,
   input wire logic [sgram_fe_pkg::BANK_W-1:0] BANK_SEL_I,
   input wire logic [sgram_fe_pkg::ADDR_W-1:0] ADDR_I,
   input wire logic [sgram_fe_pkg::DQ_W-1:0] DQ_I,
   output logic [sgram_fe_pkg::DQ_W-1:0] DQ_O,
   output logic DQ_OE_O,
   input wire logic [sgram_fe_pkg::BYTES-1:0] BYTE_INVERT_FLAGS_B_I,
   output logic [sgram_fe_pkg::BYTES-1:0] BYTE_INVERT_FLAGS_B_O,
   output logic BYTE_INVERT_FLAGS_OE_O,
   output logic [sgram_fe_pkg::BYTES-1:0] BYTE_CHECK_OUTPUTS_O,
   output logic ON_DIE_TERMINATION_O,
   input wire logic [sgram_fe_pkg::DQ_W-1:0] RD_DATA_I,
   output logic [sgram_fe_pkg::NUM_PAIRS-1:0] RD_TAKE_O,
   output logic [sgram_fe_pkg::DQ_W-1:0] WR_DATA_O,
   output logic [sgram_fe_pkg::NUM_PAIRS-1:0] WR_VALID_O,
   output logic CMD_VALID_O,
   output sgram_fe_pkg::cmd_e CMD_O,
   output logic [sgram_fe_pkg::BANK_W-1:0] CMD_BANK_O,
   output logic [sgram_fe_pkg::ADDR_W-1:0] CMD_ADDR_O,
   output logic MODE_REG_WR_O,
   output logic [sgram_fe_pkg::BANK_W-1:0] MODE_REG_SEL_O,
   output logic [sgram_fe_pkg::ADDR_W-1:0] MODE_REG_CODE_O,
   output logic [sgram_fe_pkg::NUM_BANKS-1:0] BANK_OPEN_O,
   output sgram_fe_pkg::pwr_e POWER_STATE_O
);
   import sgram_fe_pkg::*;

   typedef struct packed {
      logic [SYNC_STAGES-1:0] tgl_sync;
      logic tgl_seen;
      logic [SYNC_STAGES-1:0] cke_sync;
      logic [SYNC_STAGES-1:0] rd_sync;
      logic [SYNC_STAGES-1:0] wr_sync;
      logic [SYNC_STAGES-1:0] lo_sync;
      logic [SYNC_STAGES-1:0] hi_sync;
      logic [NUM_PAIRS-1:0] wck_prev;
      logic last_ref;
      logic cmd_valid;
      cmd_e cmd;
      logic [BANK_W-1:0] cmd_bank;
      logic [ADDR_W-1:0] cmd_addr;
      logic mr_wr;
      logic [BANK_W-1:0] mr_sel;
      logic [ADDR_W-1:0] mr_code;
      logic [NUM_BANKS-1:0] bank_open;
      pwr_e pwr;
      logic on_die_termination;
      logic [DQ_W-1:0] dq_out;
      logic dq_oe;
      logic [BYTES-1:0] dbi_out;
      logic [BYTES-1:0] edc_out;
      logic [NUM_PAIRS-1:0] rd_take;
      logic [DQ_W-1:0] wr_data;
      logic [NUM_PAIRS-1:0] wr_valid;
   } core_s;

   core_s cur_ff;
   core_s nxt_cur;
   logic [SYNC_STAGES-1:0] rst_sync_ff;
   logic rst_b;
   logic [NUM_PAIRS-1:0] wck_now;
   logic [NUM_PAIRS-1:0] wck_rise;
   logic [DQ_W-1:0] wr_plain;
   logic [DQ_W-1:0] rd_coded;
   logic [BYTES-1:0] rd_inv;
   logic [BYTES-1:0] rd_check;
   cap_if cap();

   cmd_capture #(
      .RD_LAT(RD_LAT),
      .WR_LAT(WR_LAT)
   ) u_cmd_capture (
      .cmd_clk_true_i(CMD_CLOCK_TRUE_I),
      .cmd_clk_comp_i(CMD_CLOCK_COMP_I),
      .rst_b_i(RST_B_I),
      .strobe_b_i({RAS_B_I, CAS_B_I, WE_B_I}),
      .cke_b_i(CKE_B_I),
      .bank_i(BANK_SEL_I),
      .addr_i(ADDR_I),
      .cap(cap)
   );

   // Assertion clears every flop at once; only the release waits for the clock.
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         rst_sync_ff <= '0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_b = rst_sync_ff[SYNC_STAGES-1];

   assign wck_now = {cur_ff.hi_sync[SYNC_STAGES-1], cur_ff.lo_sync[SYNC_STAGES-1]};
   assign wck_rise = wck_now & ~cur_ff.wck_prev;

   // Byte lane coding: a low flag marks an inverted byte; check data is byte parity.
   genvar gb;
   generate
      for (gb = 0; gb < BYTES; gb++) begin : g_byte
         logic [BYTE_W-1:0] rd_byte;
         assign rd_byte = RD_DATA_I[gb*BYTE_W +: BYTE_W];
         assign wr_plain[gb*BYTE_W +: BYTE_W] = BYTE_INVERT_FLAGS_B_I[gb] ?
            DQ_I[gb*BYTE_W +: BYTE_W] : ~DQ_I[gb*BYTE_W +: BYTE_W];
         // Inverting bytes with more than half zeros limits lanes pulled low.
         assign rd_inv[gb] = ($countones(rd_byte) < (BYTE_W / 2));
         assign rd_coded[gb*BYTE_W +: BYTE_W] = rd_inv[gb] ? ~rd_byte : rd_byte;
         assign rd_check[gb] = ^rd_coded[gb*BYTE_W +: BYTE_W];
      end
   endgenerate

   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.tgl_sync = {cur_ff.tgl_sync[0], cap.cmd_tgl};
      nxt_cur.cke_sync = {cur_ff.cke_sync[0], cap.cke_b};
      nxt_cur.rd_sync = {cur_ff.rd_sync[0], cap.rd_win};
      nxt_cur.wr_sync = {cur_ff.wr_sync[0], cap.wr_win};
      nxt_cur.lo_sync = {cur_ff.lo_sync[0], DATA_CLOCK_LOW_PAIR_TRUE_I};
      nxt_cur.hi_sync = {cur_ff.hi_sync[0], DATA_CLOCK_HIGH_PAIR_TRUE_I};
      nxt_cur.wck_prev = wck_now;
      nxt_cur.tgl_seen = cur_ff.tgl_sync[SYNC_STAGES-1];
      nxt_cur.cmd_valid = 1'b0;
      nxt_cur.mr_wr = 1'b0;
      nxt_cur.rd_take = '0;
      nxt_cur.wr_valid = '0;
      nxt_cur.on_die_termination = 1'b1;
      // The command word is stable for a full command cycle, longer than the sync delay.
      if (cur_ff.tgl_sync[SYNC_STAGES-1] != cur_ff.tgl_seen) begin
         nxt_cur.cmd_valid = 1'b1;
         nxt_cur.cmd = cap.cmd;
         nxt_cur.cmd_bank = cap.bank;
         nxt_cur.cmd_addr = cap.addr;
         nxt_cur.last_ref = (cap.cmd == CMD_REF);
         unique case (cap.cmd)
            CMD_ACT: nxt_cur.bank_open[cap.bank] = 1'b1;
            CMD_PRE: begin
               if (cap.addr[PRE_ALL_BIT]) begin
                  nxt_cur.bank_open = '0;
               end else begin
                  nxt_cur.bank_open[cap.bank] = 1'b0;
               end
            end
            CMD_MRS: begin
               nxt_cur.mr_wr = 1'b1;
               nxt_cur.mr_sel = cap.bank;
               nxt_cur.mr_code = cap.addr;
            end
            default: nxt_cur.last_ref = nxt_cur.last_ref;
         endcase
      end
      if (!cur_ff.cke_sync[SYNC_STAGES-1]) begin
         nxt_cur.pwr = PWR_ACTIVE;
      end else if (cur_ff.pwr == PWR_ACTIVE) begin
         if (cur_ff.last_ref) begin
            nxt_cur.pwr = PWR_SELF_REF;
         end else if (cur_ff.bank_open != '0) begin
            nxt_cur.pwr = PWR_ACT_PD;
         end else begin
            nxt_cur.pwr = PWR_PRE_PD;
         end
      end
      // Drivers stay off in power-down even if a read window is still open.
      nxt_cur.dq_oe = cur_ff.rd_sync[SYNC_STAGES-1] && !cur_ff.cke_sync[SYNC_STAGES-1];
      for (int p = 0; p < NUM_PAIRS; p++) begin
         if (wck_rise[p] && cur_ff.rd_sync[SYNC_STAGES-1] && !cur_ff.cke_sync[SYNC_STAGES-1]) begin
            nxt_cur.dq_out[p*PAIR_W +: PAIR_W] = rd_coded[p*PAIR_W +: PAIR_W];
            nxt_cur.dbi_out[p*2 +: 2] = ~rd_inv[p*2 +: 2];
            nxt_cur.edc_out[p*2 +: 2] = rd_check[p*2 +: 2];
            nxt_cur.rd_take[p] = 1'b1;
         end
         if (wck_rise[p] && cur_ff.wr_sync[SYNC_STAGES-1] && !cur_ff.cke_sync[SYNC_STAGES-1]) begin
            nxt_cur.wr_data[p*PAIR_W +: PAIR_W] = wr_plain[p*PAIR_W +: PAIR_W];
            nxt_cur.wr_valid[p] = 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_I or negedge rst_b) begin
      if (!rst_b) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign DQ_O = cur_ff.dq_out;
   assign DQ_OE_O = cur_ff.dq_oe;
   assign BYTE_INVERT_FLAGS_B_O = cur_ff.dbi_out;
   assign BYTE_INVERT_FLAGS_OE_O = cur_ff.dq_oe;
   assign BYTE_CHECK_OUTPUTS_O = cur_ff.edc_out;
   assign ON_DIE_TERMINATION_O = cur_ff.on_die_termination;
   assign RD_TAKE_O = cur_ff.rd_take;
   assign WR_DATA_O = cur_ff.wr_data;
   assign WR_VALID_O = cur_ff.wr_valid;
   assign CMD_VALID_O = cur_ff.cmd_valid;
   assign CMD_O = cur_ff.cmd;
   assign CMD_BANK_O = cur_ff.cmd_bank;
   assign CMD_ADDR_O = cur_ff.cmd_addr;
   assign MODE_REG_WR_O = cur_ff.mr_wr;
   assign MODE_REG_SEL_O = cur_ff.mr_sel;
   assign MODE_REG_CODE_O = cur_ff.mr_code;
   assign BANK_OPEN_O = cur_ff.bank_open;
   assign POWER_STATE_O = cur_ff.pwr;
endmodule

// >>> verification/sgram_fe_assertions.sv
// Concurrent checks on the outputs of the graphics DRAM pin front end.
// Assumes it is bound to the front end top and sees only its ports.
`timescale 1ns/100ps
module sgram_fe_assertions
   import sgram_fe_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RST_B_I,
   input wire logic [sgram_fe_pkg::DQ_W-1:0] DQ_O,
   input wire logic DQ_OE_O,
   input wire logic BYTE_INVERT_FLAGS_OE_O,
   input wire logic [sgram_fe_pkg::BYTES-1:0] BYTE_CHECK_OUTPUTS_O,
   input wire logic ON_DIE_TERMINATION_O,
   input wire logic [sgram_fe_pkg::NUM_PAIRS-1:0] RD_TAKE_O,
   input wire logic CMD_VALID_O,
   input sgram_fe_pkg::cmd_e CMD_O,
   input wire logic [sgram_fe_pkg::BANK_W-1:0] CMD_BANK_O,
   input wire logic [sgram_fe_pkg::ADDR_W-1:0] CMD_ADDR_O,
   input wire logic MODE_REG_WR_O,
   input wire logic [sgram_fe_pkg::BANK_W-1:0] MODE_REG_SEL_O,
   input wire logic [sgram_fe_pkg::ADDR_W-1:0] MODE_REG_CODE_O,
   input wire logic [sgram_fe_pkg::NUM_BANKS-1:0] BANK_OPEN_O,
   input sgram_fe_pkg::pwr_e POWER_STATE_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_B_I);
   // Reset acts without a clock, so the reset checks must not be disabled by it.
   property p_odt_reset;
      disable iff (1'b0) !RST_B_I |-> !ON_DIE_TERMINATION_O;
   endproperty
   a_odt_reset: assert property (p_odt_reset)
      else $error("termination on during reset");
   property p_reset_quiet;
      disable iff (1'b0) !RST_B_I |-> !CMD_VALID_O && RD_TAKE_O == '0 && !DQ_OE_O
         && BANK_OPEN_O == '0 && POWER_STATE_O == PWR_ACTIVE;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs not cleared in reset");
   property p_cmd_pulse;
      CMD_VALID_O |=> !CMD_VALID_O;
   endproperty
   a_cmd_pulse: assert property (p_cmd_pulse)
      else $error("command pulse longer than one cycle");
   property p_mode_sel;
      MODE_REG_WR_O |-> CMD_VALID_O && CMD_O == CMD_MRS && MODE_REG_SEL_O == CMD_BANK_O
         && MODE_REG_CODE_O == CMD_ADDR_O;
   endproperty
   a_mode_sel: assert property (p_mode_sel)
      else $error("mode register write not tied to its command");
   property p_act_open;
      CMD_VALID_O && CMD_O == CMD_ACT |-> ##[0:1] BANK_OPEN_O[CMD_BANK_O];
   endproperty
   a_act_open: assert property (p_act_open)
      else $error("activated bank not open");
   property p_pre_all;
      CMD_VALID_O && CMD_O == CMD_PRE && CMD_ADDR_O[PRE_ALL_BIT] |-> ##[0:1] BANK_OPEN_O == '0;
   endproperty
   a_pre_all: assert property (p_pre_all)
      else $error("precharge all left a bank open");
   property p_flag_oe;
      BYTE_INVERT_FLAGS_OE_O == DQ_OE_O;
   endproperty
   a_flag_oe: assert property (p_flag_oe)
      else $error("flag enable differs from data enable");
   property p_oe_power;
      DQ_OE_O |-> POWER_STATE_O == PWR_ACTIVE;
   endproperty
   a_oe_power: assert property (p_oe_power)
      else $error("data driven while powered down");
   property p_check_low;
      RD_TAKE_O[0] |-> BYTE_CHECK_OUTPUTS_O[1:0] == {^DQ_O[15:8], ^DQ_O[7:0]};
   endproperty
   a_check_low: assert property (p_check_low)
      else $error("low pair check bits wrong");
   property p_check_high;
      RD_TAKE_O[1] |-> BYTE_CHECK_OUTPUTS_O[3:2] == {^DQ_O[31:24], ^DQ_O[23:16]};
   endproperty
   a_check_high: assert property (p_check_high)
      else $error("high pair check bits wrong");
endmodule
bind sgram_front_end sgram_fe_assertions i_sgram_fe_assertions (.CLK_I(CLK_I),
   .RST_B_I(RST_B_I), .DQ_O(DQ_O), .DQ_OE_O(DQ_OE_O),
   .BYTE_INVERT_FLAGS_OE_O(BYTE_INVERT_FLAGS_OE_O), .ON_DIE_TERMINATION_O(ON_DIE_TERMINATION_O),
   .BYTE_CHECK_OUTPUTS_O(BYTE_CHECK_OUTPUTS_O), .RD_TAKE_O(RD_TAKE_O), .CMD_O(CMD_O),
   .CMD_VALID_O(CMD_VALID_O), .CMD_BANK_O(CMD_BANK_O), .CMD_ADDR_O(CMD_ADDR_O),
   .MODE_REG_WR_O(MODE_REG_WR_O), .MODE_REG_SEL_O(MODE_REG_SEL_O),
   .MODE_REG_CODE_O(MODE_REG_CODE_O), .BANK_OPEN_O(BANK_OPEN_O), .POWER_STATE_O(POWER_STATE_O));

// >>> verification/host_model.sv
// Host controller model driving command, address, write data and data clocks.
// Assumes the bench supplies the command clock and calls issue once per command.
`timescale 1ns/100ps
module host_model
   import sgram_fe_pkg::*;
(
   input wire logic cmd_clk_i,
   output logic [2:0] strobe_b_o,
   output logic cke_b_o,
   output logic [sgram_fe_pkg::BANK_W-1:0] bank_o,
   output logic [sgram_fe_pkg::ADDR_W-1:0] addr_o,
   output logic [sgram_fe_pkg::DQ_W-1:0] dq_o,
   output logic [sgram_fe_pkg::BYTES-1:0] flags_b_o,
   output logic wck_lo_o,
   output logic wck_hi_o
);
   logic wr_on = 1'b0;
   logic wck_on = 1'b0;
   // Outside a write the lanes carry the inverse, so stale data cannot pass for good data.
   assign dq_o = wr_on ? 32'hF0F0_1234 : 32'h0F0F_EDCB;
   assign flags_b_o = wr_on ? 4'hB : 4'h4;
   initial begin
      strobe_b_o = 3'h7;
      cke_b_o = 1'b0;
      bank_o = 4'h0;
      addr_o = 16'h0000;
      wck_lo_o = 1'b0;
      wck_hi_o = 1'b0;
      forever begin
         #20 wck_hi_o = wck_on & ~wck_hi_o;
         #20 wck_lo_o = wck_on & ~wck_lo_o;
      end
   end
   // Each pin half is valid only around its own sampling edge; the other bits are wrong.
   task automatic issue(input logic [2:0] code, input logic [3:0] bank, input logic [15:0] addr,
         input logic cke_b);
      @(negedge cmd_clk_i);
      strobe_b_o <= code;
      cke_b_o <= cke_b;
      bank_o <= bank;
      addr_o <= addr ^ ~ADDR_TRUE_MASK;
      @(posedge cmd_clk_i);
      strobe_b_o <= 3'h7;
      bank_o <= ~bank;
      addr_o <= addr ^ ADDR_TRUE_MASK;
   endtask
endmodule

// >>> verification/sgram_front_end_test.sv
// Self-checking bench for the graphics DRAM pin front end.
// Assumes the host model drives the pins and the checker is bound to the top.
`timescale 1ns/100ps
module sgram_front_end_test;
   import sgram_fe_pkg::*;
   localparam logic [2:0] CODES [4] = '{STB_ACT, STB_MRS, STB_REF, STB_PRE};
   localparam cmd_e EXPS [4] = '{CMD_ACT, CMD_MRS, CMD_REF, CMD_PRE};
   logic clk, rst_b, ck_t, cke_b, wck_lo, wck_hi, dq_oe, on_die_termination, cmd_valid, mr_wr;
   logic [2:0] stb;
   logic [3:0] bank, flg_in, flg_out, chk, cmd_bank, mr_sel;
   logic [15:0] addr, cmd_addr, mr_code, bank_open;
   logic [31:0] dq_in, dq_out, rd_data, wr_data;
   logic [1:0] rd_take, wr_valid;
   cmd_e cmd;
   pwr_e pwr;
   int fails = 0;
   int n_compared = 0;
   sgram_front_end i_sgram_front_end (.CLK_I(clk), .RST_B_I(rst_b), .CMD_CLOCK_TRUE_I(ck_t),
      .CMD_CLOCK_COMP_I(~ck_t), .DATA_CLOCK_LOW_PAIR_TRUE_I(wck_lo),
      .DATA_CLOCK_HIGH_PAIR_TRUE_I(wck_hi), .RAS_B_I(stb[2]), .CAS_B_I(stb[1]),
      .WE_B_I(stb[0]), .CKE_B_I(cke_b), .BANK_SEL_I(bank), .ADDR_I(addr), .DQ_I(dq_in),
      .DQ_O(dq_out), .DQ_OE_O(dq_oe), .BYTE_INVERT_FLAGS_B_I(flg_in),
      .BYTE_INVERT_FLAGS_B_O(flg_out), .BYTE_INVERT_FLAGS_OE_O(), .BYTE_CHECK_OUTPUTS_O(chk),
      .ON_DIE_TERMINATION_O(on_die_termination), .RD_DATA_I(rd_data), .RD_TAKE_O(rd_take),
      .WR_DATA_O(wr_data), .WR_VALID_O(wr_valid), .CMD_VALID_O(cmd_valid), .CMD_O(cmd),
      .CMD_BANK_O(cmd_bank), .CMD_ADDR_O(cmd_addr), .MODE_REG_WR_O(mr_wr),
      .MODE_REG_SEL_O(mr_sel), .MODE_REG_CODE_O(mr_code), .BANK_OPEN_O(bank_open),
      .POWER_STATE_O(pwr));
   host_model i_host_model (.cmd_clk_i(ck_t), .strobe_b_o(stb), .cke_b_o(cke_b),
      .bank_o(bank), .addr_o(addr), .dq_o(dq_in), .flags_b_o(flg_in), .wck_lo_o(wck_lo),
      .wck_hi_o(wck_hi));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      ck_t = 1'b0;
      #7;
      forever #32 ck_t = ~ck_t;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] expected);
      n_compared++;
      if (seen !== expected) begin
         fails++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, expected);
      end
   endtask
   task automatic test_done;
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic cmd_go(input logic [2:0] code, input cmd_e exp, input logic [3:0] b,
         input logic [15:0] a);
      i_host_model.issue(code, b, a, 1'b0);
      for (int i = 0; i < 20; i++) begin
         @(posedge clk);
         #1;
         if (cmd_valid === 1'b1) begin
            check({cmd, cmd_bank, cmd_addr}, {exp, b, a});
            return;
         end
      end
      check(1'b0, 1'b1);
      test_done;
   endtask
   task automatic wait_pwr(input pwr_e p);
      for (int i = 0; i < 20 && pwr !== p; i++) begin
         @(posedge clk);
         #1;
      end
      check(pwr, p);
      if (pwr !== p) test_done;
   endtask
   task automatic t_decode;
      for (int i = 0; i < 4; i++) begin
         cmd_go(CODES[i], EXPS[i], 4'(3 * i + 2), 16'hA5C3 + 16'(i));
         @(posedge clk);
         #1;
         if (i == 1) check({mr_sel, mr_code}, {4'h5, 16'hA5C4});
         if (i == 3) check(bank_open, 16'h0000);
      end
      $display("decode test done");
   endtask
   task automatic t_data(input logic wr);
      int n0;
      int n1;
      n0 = 0;
      n1 = 0;
      i_host_model.wr_on = wr;
      cmd_go(STB_ACT, CMD_ACT, 4'h1, 16'h0123);
      if (wr) cmd_go(STB_WR, CMD_WR, 4'h1, 16'h0080);
      else cmd_go(STB_RD, CMD_RD, 4'h1, 16'h0040);
      i_host_model.wck_on = 1'b1;
      for (int i = 0; i < 80; i++) begin
         @(posedge clk);
         #1;
         if (!wr && rd_take[0] === 1'b1) begin
            n0++;
            check({dq_oe, dq_out[15:0], flg_out[1:0], chk[1:0]}, {1'b1, 16'h0FFE, 4'h9});
         end
         if (!wr && rd_take[1] === 1'b1) begin
            n1++;
            check({dq_out[31:16], flg_out[3:2], chk[3:2]}, {16'hFFFF, 4'h4});
         end
         if (wr && wr_valid[0] === 1'b1) begin
            n0++;
            check(wr_data[15:0], 16'h1234);
         end
         if (wr && wr_valid[1] === 1'b1) begin
            n1++;
            check(wr_data[31:16], 16'hF00F);
         end
      end
      i_host_model.wck_on = 1'b0;
      i_host_model.wr_on = 1'b0;
      check(n0 > 0 && n1 > 0, 1'b1);
      $display("data test done");
   endtask
   task automatic t_power;
      logic saw;
      saw = 1'b0;
      i_host_model.issue(3'h7, 4'h0, 16'h0000, 1'b1);
      wait_pwr(PWR_ACT_PD);
      i_host_model.issue(STB_WR, 4'h2, 16'h0000, 1'b1);
      repeat (15) begin
         @(posedge clk);
         #1;
         saw = saw | cmd_valid;
      end
      check(saw, 1'b0);
      i_host_model.issue(3'h7, 4'h0, 16'h0000, 1'b0);
      wait_pwr(PWR_ACTIVE);
      cmd_go(STB_PRE, CMD_PRE, 4'h0, 16'h0100);
      i_host_model.issue(3'h7, 4'h0, 16'h0000, 1'b1);
      wait_pwr(PWR_PRE_PD);
      i_host_model.issue(3'h7, 4'h0, 16'h0000, 1'b0);
      cmd_go(STB_REF, CMD_REF, 4'h3, 16'h0000);
      i_host_model.issue(3'h7, 4'h0, 16'h0000, 1'b1);
      wait_pwr(PWR_SELF_REF);
      i_host_model.issue(3'h7, 4'h0, 16'h0000, 1'b0);
      wait_pwr(PWR_ACTIVE);
      $display("power test done");
   endtask
   task automatic do_reset;
      @(posedge clk);
      rst_b <= 1'b0;
      #2;
      check({cmd_valid, rd_take, dq_oe, on_die_termination, bank_open}, 21'h0);
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      repeat (12) @(posedge clk);
      #1;
      check(on_die_termination, 1'b1);
   endtask
   initial begin
      rst_b = 1'b0;
      rd_data = 32'h00FF_0F01;
      do_reset;
      t_decode;
      t_data(1'b0);
      t_data(1'b1);
      t_power;
      cmd_go(STB_ACT, CMD_ACT, 4'h7, 16'h0011);
      do_reset;
      cmd_go(STB_ACT, CMD_ACT, 4'h9, 16'h0022);
      $display("reset test done");
      test_done;
   end
endmodule
